// ==== src/frtt_pkg.sv ====
package frtt_pkg;
    // Printed offsets 0x24/0x25 are only one apart: they are word indices
    localparam logic [7:0] FRTT_IDX_LOW = 8'h24;
    localparam logic [7:0] FRTT_IDX_HIGH = 8'h25;
    localparam int FRTT_ADDR_W = 10;
    localparam logic [FRTT_ADDR_W-1:0] FRTT_ADDR_LOW = {FRTT_IDX_LOW, 2'b00};
    localparam logic [FRTT_ADDR_W-1:0] FRTT_ADDR_HIGH = {FRTT_IDX_HIGH, 2'b00};
    localparam int FRTT_CNT_W = 12;
    localparam int FRTT_LOW_LSB = 0;
    localparam int FRTT_LOW_MSB = 7;
    localparam int FRTT_HIGH_LSB = 8;
    localparam int FRTT_HIGH_MSB = 11;
    localparam logic [FRTT_CNT_W-1:0] FRTT_CNT_RST = 12'h000;
    localparam logic [3:0] FRTT_HOLD_RST = 4'h0;
    localparam int FRTT_CLK_HZ = 10_000_000;
    localparam int FRTT_TICK_NS = 1000;
    localparam int FRTT_TICK_CYC = FRTT_CLK_HZ / 1_000_000 * FRTT_TICK_NS / 1000;
    // Interrupt periods in microseconds, i.e. in ticks
    localparam int FRTT_IRQ_A_US = 128;
    localparam int FRTT_IRQ_B_US = 1024;
    localparam int FRTT_IRQ_A_BIT = 7;
    localparam int FRTT_IRQ_B_BIT = 10;
endpackage : frtt_pkg

// ==== src/frtt_tick_gen.sv ====
`timescale 1ns/100ps
module frtt_tick_gen
    import frtt_pkg::*;
#(
    parameter int DIV = FRTT_TICK_CYC
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Tick
    output logic tick_o
);
    localparam int W = $clog2(DIV + 1);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] div_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= '0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            tick_o <= (div_q == LAST);
            if (div_q == LAST) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + W'(1);
            end
        end
    end
endmodule : frtt_tick_gen

// ==== src/frtt_timer.sv ====
// Summary of operation
// - Twelve-bit counter free-runs, one step per one-microsecond tick.
// - Two periodic interrupt pulses: every 128 us and every 1.024 ms.
// - Low byte register read returns live count bits seven to zero.
// - Reading the low byte latches the upper four count bits.
// - High byte register read returns the latched nibble, not live bits.
// - High byte bits three to zero hold count 11..8; upper bits zero.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
module frtt_timer
    import frtt_pkg::*;
#(
    parameter int TICK_DIV = FRTT_TICK_CYC
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [FRTT_ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Periodic interrupt requests
    output logic irq_128us_o,
    output logic irq_1ms_o
);
    ////////////////////////////////////////////////////////////////////////
    logic tick;
    logic [FRTT_CNT_W-1:0] count_q;
    logic [3:0] hold_q;
    logic req;
    logic hit_low;
    logic hit_high;

    frtt_tick_gen #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= FRTT_CNT_RST;
        end else if (ce_i && tick) begin
            count_q <= count_q + 12'h001; // Natural wrap
        end
    end

    // Pulse when the lower bits roll over: periods of 128 and 1024 ticks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_128us_o <= 1'b0;
            irq_1ms_o <= 1'b0;
        end else if (ce_i) begin
            irq_128us_o <= tick && (&count_q[FRTT_IRQ_A_BIT-1:0]);
            irq_1ms_o <= tick && (&count_q[FRTT_IRQ_B_BIT-1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ack pulse of one cycle; request ignored while ack is high
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign hit_low = (adr_i == FRTT_ADDR_LOW);
    assign hit_high = (adr_i == FRTT_ADDR_HIGH);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else if (ce_i) begin
            // Writes to mapped read-only registers are acked and dropped
            ack_o <= req && (hit_low || hit_high);
            err_o <= req && !(hit_low || hit_high);
            if (req && !we_i && hit_low) begin
                dat_o <= {24'h000000, count_q[FRTT_LOW_MSB:FRTT_LOW_LSB]};
            end else if (req && !we_i && hit_high) begin
                dat_o <= {28'h0000000, hold_q};
            end else begin
                dat_o <= 32'h00000000;
            end
        end
    end

    // Latch only on reads; a later high read stays coherent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_q <= FRTT_HOLD_RST;
        end else if (ce_i && req && !we_i && hit_low) begin
            hold_q <= count_q[FRTT_HIGH_MSB:FRTT_HIGH_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checking aids: ticks counted since the last pulse of each interrupt
    logic [10:0] gap_q;
    logic [7:0] gap_fast_q;

    // Saturating, so a lost pulse shows up as a wrong spacing, not a wrap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_q <= '0;
        end else if (ce_i) begin
            // A tick in the pulse cycle already belongs to the next period
            if (irq_1ms_o) begin
                gap_q <= {10'h000, tick};
            end else if (tick && gap_q != 11'h7FF) begin
                gap_q <= gap_q + 11'h001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_fast_q <= '0;
        end else if (ce_i) begin
            if (irq_128us_o) begin
                gap_fast_q <= {7'h00, tick};
            end else if (tick && gap_fast_q != 8'hFF) begin
                gap_fast_q <= gap_fast_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter
    a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && tick) |=> (count_q == $past(count_q) + 12'h001))
        else $error("counter did not advance on tick");
    a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ce_i && tick) |=> $stable(count_q))
        else $error("counter moved without tick");
    a_count_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && tick && count_q == 12'hFFF) |=> count_q == 12'h000)
        else $error("counter did not wrap to zero");
    a_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> ($stable(count_q) && $stable(hold_q) && $stable(ack_o)))
        else $error("state moved while clock enable was low");

    // Interrupts: one pulse per period, one cycle wide
    a_irq_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_128us_o) |-> $past(count_q[6:0]) == 7'h7F)
        else $error("128 us pulse at wrong count");
    a_irq_slow: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_1ms_o) |-> (irq_128us_o && $past(count_q[9:0]) == 10'h3FF))
        else $error("1 ms pulse at wrong count");
    a_irq_period: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_1ms_o |-> gap_q == 11'(FRTT_IRQ_B_US))
        else $error("1 ms spacing wrong");
    a_fast_period: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_128us_o |-> gap_fast_q == 8'(FRTT_IRQ_A_US))
        else $error("128 us spacing wrong");
    a_irq_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && tick && count_q[6:0] == 7'h7F) |=> irq_128us_o)
        else $error("128 us pulse missing");
    a_fast_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && irq_128us_o) |=> !irq_128us_o)
        else $error("128 us pulse longer than one cycle");
    a_slow_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && irq_1ms_o) |=> !irq_1ms_o)
        else $error("1 ms pulse longer than one cycle");
    a_irq_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !tick) |=> (!irq_128us_o && !irq_1ms_o))
        else $error("interrupt pulse without a tick");

    // Register reads
    a_low_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && !we_i && hit_low) |=> (ack_o && dat_o[7:0] == $past(count_q[7:0])))
        else $error("low byte read data wrong");
    a_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && !we_i && hit_low) |=> dat_o[31:8] == 24'h000000)
        else $error("upper bits of low byte read not zero");
    a_hold_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && !we_i && hit_low) |=> hold_q == $past(count_q[11:8]))
        else $error("nibble not latched on low read");
    a_hold_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ce_i && req && !we_i && hit_low) |=> $stable(hold_q))
        else $error("nibble changed without a low read");
    a_high_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && !we_i && hit_high) |=> (ack_o && dat_o == {28'h0, $past(hold_q)}))
        else $error("high byte read data wrong");
    a_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ack_o) && $past(hit_high) |-> dat_o[31:4] == 28'h0)
        else $error("reserved high bits not zero");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && ack_o) |=> !ack_o)
        else $error("ack longer than one cycle");
    a_err_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && err_o) |=> !err_o)
        else $error("err longer than one cycle");
    a_err_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && !(hit_low || hit_high)) |=> (err_o && !ack_o))
        else $error("unmapped access not refused");
    a_write_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && we_i) |=> dat_o == 32'h00000000)
        else $error("write answered with data");

    // Reset
    a_reset_clear: assert property (@(posedge clk_i)
        rst_i |=> (count_q == 12'h000 && hold_q == 4'h0))
        else $error("reset did not clear state");
    a_reset_outputs: assert property (@(posedge clk_i)
        rst_i |=> (!ack_o && !err_o && !irq_128us_o && !irq_1ms_o && dat_o == 32'h00000000))
        else $error("reset did not clear outputs");

    // Coverage of the main scenarios
    c_low_read: cover property (@(posedge clk_i) ack_o && hit_low && !we_i);
    c_high_read: cover property (@(posedge clk_i) ack_o && hit_high && !we_i);
    c_irq_slow: cover property (@(posedge clk_i) irq_1ms_o);
    c_wrap: cover property (@(posedge clk_i) count_q == 12'hFFF ##1 count_q == 12'h000);
    c_freeze: cover property (@(posedge clk_i) !ce_i ##1 ce_i);
endmodule : frtt_timer

// ==== tb/frtt_timer_tb.sv ====
`timescale 1ns/100ps
module frtt_timer_tb;
    import frtt_pkg::*;
    localparam int DIV = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [FRTT_ADDR_W-1:0] adr_i = '0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, err_o, irq_128us_o, irq_1ms_o;
    // Note: {compare data, expect err, data}
    logic [33:0] exp_q[$];
    logic [33:0] e_m;
    logic [31:0] rng = 32'hC59DC158;
    int cyc_n = 0;
    int errors = 0;
    int num_checks = 0;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;
    frtt_timer #(.TICK_DIV(DIV)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .irq_128us_o(irq_128us_o), .irq_1ms_o(irq_1ms_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] want);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, want, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // Classic single cycle, held until the answer is sampled; the watchdog ends a hang
    task automatic wb(input logic [FRTT_ADDR_W-1:0] a, input logic w, input logic [33:0] e);
        exp_q.push_back(e);
        rng = xs(rng);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= rng[3:0];
        dat_i <= rng;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 || err_o === 1'b1) begin
            e_m = exp_q.size() > 0 ? exp_q.pop_front() : 34'h1FFFFFFFF;
            check("bus answer", {err_o, dat_o & {32{e_m[33]}}}, e_m[32:0]);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k, last, span;
        logic [11:0] v;
        logic [3:0] hold;
        logic [FRTT_ADDR_W-1:0] a;
        last = 0;
        span = 0;
        hold = 4'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(FRTT_ADDR_LOW, 1'b0, {2'b10, 32'h0});
        wb(FRTT_ADDR_HIGH, 1'b0, {2'b10, 32'h0});
        for (k = 1; k <= 33; k++) begin
            while (irq_128us_o !== 1'b1) @(posedge clk_i);
            if (k > 1) check("irq period", 33'(cyc_n - last), 33'(DIV * 128));
            last = cyc_n;
            check("irq 1ms", {32'h0, irq_1ms_o}, 33'(k % 8 == 0));
            v = 12'(128 * k);
            // Even steps: stale nibble first, then a coherent pair
            if (k % 2 == 0) begin
                wb(FRTT_ADDR_HIGH, 1'b0, {2'b10, 28'h0, hold});
            end
            wb(FRTT_ADDR_LOW, 1'b0, {2'b10, 24'h0, v[7:0]});
            hold = v[11:8];
            if (k % 2 == 0) begin
                wb(FRTT_ADDR_HIGH, 1'b0, {2'b10, 28'h0, hold});
            end
            wb(rng[0] ? FRTT_ADDR_LOW : FRTT_ADDR_HIGH, 1'b1, {2'b00, 32'h0});
            a = rng[FRTT_ADDR_W-1:0];
            if (a == FRTT_ADDR_LOW || a == FRTT_ADDR_HIGH) a ^= 10'h001;
            wb(a, rng[1], {2'b01, 32'h0});
            // Random freeze; the next interrupt comes exactly that much later
            if (k == 20) begin
                span = 1 + int'(rng[3:0]);
                ce_i <= 1'b0;
                repeat (span) @(posedge clk_i);
                ce_i <= 1'b1;
                last += span;
            end
        end
        check("answers left", 33'(exp_q.size()), 33'h0);
        report_and_stop();
    end
    initial begin
        #(100 * 46000);
        errors++;
        report_and_stop();
    end
endmodule : frtt_timer_tb
